// *** rtl/drc_pkg.sv ***
// constants for the dac reset and reference control block
package drc_pkg;
    localparam int          FRAME_BITS    = 24;
    localparam int          CMD_MSB       = 21;
    localparam int          CMD_LSB       = 19;
    localparam int          RSV_BIT       = 23;
    localparam int          ADDR_MSB      = 18;
    localparam int          ADDR_LSB      = 16;
    localparam int          PD_MSB        = 5;
    localparam int          PD_LSB        = 4;
    localparam int          MODE_BIT      = 0;
    localparam logic [2:0]  CMD_WRITE_IN  = 3'h0;
    localparam logic [2:0]  CMD_UPDATE    = 3'h1;
    localparam logic [2:0]  CMD_WRITE_UPD = 3'h3;
    localparam logic [2:0]  CMD_POWERDOWN = 3'h4;
    localparam logic [2:0]  CMD_RESET     = 3'h5;
    localparam logic [2:0]  CMD_LOAD_CTRL = 3'h6;
    localparam logic [2:0]  CMD_REF_SETUP = 3'h7;
    localparam logic [3:0]  LOAD_CTRL_RST = 4'h0;
    localparam logic [7:0]  PD_RST        = 8'h00;
    localparam logic        REF_RST       = 1'b0;
    localparam int          POR_CYCLES    = 16;
endpackage

// *** rtl/drc_channel.sv ***
// one dac channel: input register, dac register and change tracking
`timescale 1ns/10ps
module drc_channel #(
    parameter int WIDTH = 16
) (
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic             por_clear,
    input  wire logic             soft_clear,
    input  wire logic [WIDTH-1:0] por_level,
    input  wire logic             write_in,
    input  wire logic [WIDTH-1:0] write_data,
    input  wire logic             load_now,
    output logic      [WIDTH-1:0] dac_value
);
    logic [WIDTH-1:0] input_reg;
    logic             pending;
    logic [WIDTH-1:0] next_input_reg;
    logic             next_pending;
    logic [WIDTH-1:0] next_dac_value;

    always_comb begin
        next_input_reg = input_reg;
        next_pending   = pending;
        next_dac_value = dac_value;
        if (por_clear) begin
            next_input_reg = por_level;
            next_dac_value = por_level;
            next_pending   = 1'b0;
        end else if (soft_clear) begin
            next_input_reg = '0;
            next_dac_value = '0;
            next_pending   = 1'b0;
        end else begin
            if (write_in) begin
                next_input_reg = write_data;
                next_pending   = 1'b1;
            end
            // only a changed input register reaches the dac register
            if (load_now && (pending || write_in)) begin
                next_dac_value = write_in ? write_data : input_reg;
                next_pending   = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            input_reg <= '0;
            pending   <= 1'b0;
            dac_value <= '0;
        end else begin
            input_reg <= next_input_reg;
            pending   <= next_pending;
            dac_value <= next_dac_value;
        end
    end
endmodule

// *** rtl/drc_top.sv ***
// reset, reference and command control for a quad dac
`timescale 1ns/10ps
module drc_top
    import drc_pkg::*;
#(
    parameter int  WIDTH      = 16,
    parameter bit  HAS_POR_PIN = 1'b1
) (
    input  wire logic                          mclk,
    input  wire logic                          nrst,
    input  wire logic                          por_level_sel,
    input  wire logic                          frame_valid,
    input  wire logic [drc_pkg::FRAME_BITS-1:0] frame_data,
    input  wire logic                          load_dac_strobe_n,
    input  wire logic                          clear_strobe_n,
    output logic      [WIDTH-1:0]              dac_a,
    output logic      [WIDTH-1:0]              dac_b,
    output logic      [WIDTH-1:0]              dac_c,
    output logic      [WIDTH-1:0]              dac_d,
    output logic      [7:0]                    powerdown_modes,
    output logic      [3:0]                    load_ctrl,
    output logic                               ref_enable,
    output logic                               por_busy
);
    import drc_pkg::*;

    logic        rst_meta;
    logic        rst_n;
    logic [4:0]  por_count;
    logic [4:0]  next_por_count;
    logic        next_por_busy;
    logic        por_start;
    logic        next_por_start;
    logic        por_mid;
    logic        next_por_mid;
    logic [7:0]  next_pd;
    logic [3:0]  next_load_ctrl;
    logic        next_ref;
    logic        soft_clear;
    logic        full_clear;
    logic [2:0]  cmd;
    logic [2:0]  addr;
    logic [WIDTH-1:0] wdata;
    logic [WIDTH-1:0] por_level;
    logic [3:0]  sel;
    logic [3:0]  write_in;
    logic [3:0]  load_now;
    logic        strobe_low;
    logic [WIDTH-1:0] dac_out [4];
    logic        frame_ok;
    logic        do_write;
    logic        do_update;
    logic        do_powerdown;
    logic        do_load_ctrl;
    logic        do_ref;

    // reset release through two flip-flops
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    assign cmd   = frame_data[CMD_MSB:CMD_LSB];
    assign addr  = frame_data[ADDR_MSB:ADDR_LSB];
    assign wdata = frame_data[WIDTH-1:0];

    // a frame takes effect only once power-on is over; frame_valid
    // pulses only after all 24 bits are in and acked
    always_comb begin
        frame_ok     = frame_valid && !por_busy;
        full_clear   = 1'b0;
        soft_clear   = 1'b0;
        do_write     = 1'b0;
        do_update    = 1'b0;
        do_powerdown = 1'b0;
        do_load_ctrl = 1'b0;
        do_ref       = 1'b0;
        if (frame_ok) begin
            case (cmd)
                CMD_WRITE_IN: begin
                    do_write = 1'b1;
                end
                CMD_UPDATE: begin
                    do_update = 1'b1;
                end
                CMD_WRITE_UPD: begin
                    do_write  = 1'b1;
                    do_update = 1'b1;
                end
                CMD_POWERDOWN: begin
                    do_powerdown = 1'b1;
                end
                CMD_RESET: begin
                    // only the scope bit counts; the rest is don't-care
                    full_clear = frame_data[MODE_BIT];
                    soft_clear = !frame_data[MODE_BIT];
                end
                CMD_LOAD_CTRL: begin
                    do_load_ctrl = 1'b1;
                end
                CMD_REF_SETUP: begin
                    do_ref = 1'b1;
                end
                default: begin
                    do_write = 1'b0;
                end
            endcase
        end
    end

    // power-on sequence: level sampled once as each sequence starts, not under reset
    always_comb begin
        next_por_count = por_count;
        next_por_busy  = por_busy;
        next_por_start = 1'b0;
        next_por_mid   = por_mid;
        if (por_busy) begin
            if (por_count == 5'h0) begin
                next_por_mid   = HAS_POR_PIN ? por_level_sel : 1'b0;
                next_por_start = 1'b1;
            end
            if (por_count == 5'(POR_CYCLES - 1)) begin
                next_por_busy = 1'b0;
            end else begin
                next_por_count = por_count + 5'h1;
            end
        end else if (full_clear) begin
            next_por_busy  = 1'b1;
            next_por_count = 5'h0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            por_count <= 5'h0;
            por_busy  <= 1'b1;
            por_start <= 1'b0;
            por_mid   <= 1'b0;
        end else begin
            por_count <= next_por_count;
            por_busy  <= next_por_busy;
            por_start <= next_por_start;
            por_mid   <= next_por_mid;
        end
    end

    // zero scale or midscale
    assign por_level = por_mid ? {1'b1, {(WIDTH-1){1'b0}}} : '0;

    // configuration registers
    always_comb begin
        next_pd        = powerdown_modes;
        next_load_ctrl = load_ctrl;
        next_ref       = ref_enable;
        if (por_start) begin
            next_pd        = PD_RST;
            next_load_ctrl = LOAD_CTRL_RST;
            next_ref       = REF_RST;
        end else if (do_powerdown) begin
            for (int ch = 0; ch < 4; ch++) begin
                if (frame_data[ch]) begin
                    next_pd[2*ch +: 2] = frame_data[PD_MSB:PD_LSB];
                end
            end
        end else if (do_load_ctrl) begin
            next_load_ctrl = frame_data[3:0];
        end else if (do_ref) begin
            next_ref = frame_data[MODE_BIT];
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            powerdown_modes <= PD_RST;
            load_ctrl       <= LOAD_CTRL_RST;
            ref_enable      <= REF_RST;
        end else begin
            powerdown_modes <= next_pd;
            load_ctrl       <= next_load_ctrl;
            ref_enable      <= next_ref;
        end
    end

    // strobes are masked during power-on; clear drives outputs to zero
    assign strobe_low = !load_dac_strobe_n && !por_busy;

    // address 7 reaches all four channels, 4 to 6 reach none
    always_comb begin
        sel = 4'h0;
        if (addr == 3'h7) begin
            sel = 4'hf;
        end else if (addr < 3'h4) begin
            sel = 4'(4'h1 << addr[1:0]);
        end
    end

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : gen_ch
            assign write_in[g] = do_write && sel[g];
            assign load_now[g] = !por_busy && (strobe_low || load_ctrl[g]
                                 || (do_update && sel[g]));
            drc_channel #(.WIDTH(WIDTH)) u_ch (
                .mclk       (mclk),
                .rst_n      (rst_n),
                .por_clear  (por_start),
                .soft_clear (soft_clear
                             || (!clear_strobe_n && !por_busy)),
                .por_level  (por_level),
                .write_in   (write_in[g]),
                .write_data (wdata),
                .load_now   (load_now[g]),
                .dac_value  (dac_out[g])
            );
        end
    endgenerate

    assign dac_a = dac_out[0];
    assign dac_b = dac_out[1];
    assign dac_c = dac_out[2];
    assign dac_d = dac_out[3];
endmodule

// *** verification/drc_asserts.sv ***
// port assertions for the reset and reference control block
`timescale 1ns/10ps
module drc_asserts
    import drc_pkg::*;
#(
    parameter int WIDTH       = 16,
    parameter bit HAS_POR_PIN = 1'b1
) (
    input wire logic             mclk,
    input wire logic             nrst,
    input wire logic             por_level_sel,
    input wire logic             frame_valid,
    input wire logic [23:0]      frame_data,
    input wire logic [WIDTH-1:0] dac_a,
    input wire logic [WIDTH-1:0] dac_b,
    input wire logic [WIDTH-1:0] dac_c,
    input wire logic [WIDTH-1:0] dac_d,
    input wire logic [7:0]       powerdown_modes,
    input wire logic [3:0]       load_ctrl,
    input wire logic             ref_enable,
    input wire logic             por_busy
);
    logic [4:0]       bcnt;
    logic [4:0]       next_bcnt;
    logic [2:0]       cmd;
    logic             go;
    logic [WIDTH-1:0] lvl;
    assign cmd = frame_data[21:19];
    assign go  = frame_valid & ~por_busy;
    assign lvl = {HAS_POR_PIN & por_level_sel, {(WIDTH-1){1'b0}}};
    // counts busy cycles; cleared whenever the power-on sequence ends
    always_comb begin
        next_bcnt = por_busy ? bcnt + 5'h1 : 5'h0;
    end
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            bcnt <= 5'h0;
        end else begin
            bcnt <= next_bcnt;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    chk_ref_setup: assert property (go && cmd == CMD_REF_SETUP
        |=> ref_enable == $past(frame_data[0])) else $error("ref setup");
    chk_ref_hold: assert property ($changed(ref_enable) && !por_busy
        |-> $past(go && cmd == CMD_REF_SETUP)) else $error("ref moved");
    chk_pd_update: assert property (go && cmd == CMD_POWERDOWN
        |=> powerdown_modes[1:0] == ($past(frame_data[0]) ?
        $past(frame_data[5:4]) : $past(powerdown_modes[1:0])))
        else $error("powerdown");
    chk_soft_keep: assert property (go && cmd == CMD_RESET && !frame_data[0]
        |=> dac_a == 0 && dac_d == 0 && $stable(load_ctrl)
        && $stable(powerdown_modes) && $stable(ref_enable))
        else $error("soft reset");
    chk_full_reset: assert property (go && cmd == CMD_RESET
        && frame_data[0] |-> ##[1:2] por_busy) else $error("no por");
    chk_busy_length: assert property ($fell(por_busy)
        |-> bcnt inside {[POR_CYCLES-1:POR_CYCLES+3]}) else $error("len");
    chk_busy_quiet: assert property (bcnt >= 5'h6
        |-> $stable(dac_a) && $stable(dac_b)) else $error("busy change");
    chk_powerup_level: assert property ($fell(por_busy)
        |-> dac_a == lvl && dac_c == lvl && ref_enable == 1'b0
        && load_ctrl == 4'h0 && powerdown_modes == 8'h00)
        else $error("power-up state");
    cover property (go && cmd == CMD_REF_SETUP);
    cover property (go && cmd == CMD_RESET && !frame_data[0]);
    cover property ($fell(por_busy));
endmodule

bind drc_top drc_asserts #(.WIDTH(WIDTH), .HAS_POR_PIN(HAS_POR_PIN)) u_chk (
    .mclk, .nrst, .por_level_sel, .frame_valid, .frame_data, .dac_a,
    .dac_b, .dac_c, .dac_d, .powerdown_modes, .load_ctrl, .ref_enable,
    .por_busy);

// *** verification/drc_master.sv ***
// frame source standing in for the serial bus master
`timescale 1ns/10ps
module drc_master (
    input  wire logic        mclk,
    input  wire logic        go,
    input  wire logic [23:0] word,
    output logic             fv,
    output logic [23:0]      fd
);
    logic        next_fv;
    logic [23:0] next_fd;
    always_comb begin
        next_fv = go; // one acked frame per request
        // reserved bit sent as 0; idle bus flips every cycle
        next_fd = go ? {1'b0, word[22:0]} : ~fd;
    end
    always_ff @(posedge mclk) begin
        fv <= next_fv;
        fd <= next_fd;
    end
endmodule

// *** verification/dac_reset_and_reference_control_test.sv ***
// testbench for the reset and reference control block
`timescale 1ns/10ps
module dac_reset_and_reference_control_test;
    logic        mclk = 0;
    logic        nrst = 0;
    logic        sel = 1;
    logic        go = 0;
    logic [23:0] word = 0;
    logic        ld_n = 1;
    logic        clr_n = 1;
    logic        fv;
    logic [23:0] fd;
    logic [15:0] da, db, dc, dd;
    logic [7:0]  pd;
    logic [3:0]  lc;
    logic        re;
    logic        busy;
    logic [15:0] za, zb, zc, zd;
    int          err_count = 0;
    int          check_count = 0;
    always #5 mclk = ~mclk;
    drc_master u_mst (.mclk(mclk), .go(go), .word(word), .fv(fv), .fd(fd));
    drc_top u_dut (.mclk(mclk), .nrst(nrst), .por_level_sel(sel),
        .frame_valid(fv), .frame_data(fd), .load_dac_strobe_n(ld_n),
        .clear_strobe_n(clr_n), .dac_a(da), .dac_b(db), .dac_c(dc),
        .dac_d(dd), .powerdown_modes(pd), .load_ctrl(lc),
        .ref_enable(re), .por_busy(busy));
    // variant without the level pin; shares every input with u_dut
    drc_top #(.HAS_POR_PIN(1'b0)) u_dut_fixed (.mclk(mclk), .nrst(nrst),
        .por_level_sel(sel), .frame_valid(fv), .frame_data(fd),
        .load_dac_strobe_n(ld_n), .clear_strobe_n(clr_n), .dac_a(za),
        .dac_b(zb), .dac_c(zc), .dac_d(zd), .powerdown_modes(),
        .load_ctrl(), .ref_enable(), .por_busy());
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // compares all four dacs and the configuration outputs at once
    task automatic st(input logic [15:0] v, input logic [7:0] p,
                      input logic [3:0] l, input logic r, input int t);
        check_count++;
        if ({da, db, dc, dd, pd, lc, re} !== {{4{v}}, p, l, r}) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time,
                {da, db, dc, dd, pd, lc, re}, {{4{v}}, p, l, r});
        end
        $display("test %0d done", t);
    endtask
    // the variant without the level pin has only its dac words checked
    task automatic zs(input logic [15:0] v);
        check_count++;
        if ({za, zb, zc, zd} !== {4{v}}) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, {za, zb, zc, zd},
                {4{v}});
        end
    endtask
    task automatic send(input logic [23:0] w);
        go <= 1'b1;
        word <= w;
        @(posedge mclk);
        go <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask
    task automatic idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 100) begin
            @(posedge mclk);
            n++;
        end
        if (n == 100) begin
            err_count++;
            test_done();
        end
        repeat (2) @(posedge mclk);
    endtask
    initial begin
        repeat (16) @(posedge mclk);
        nrst <= 1'b1;
        ld_n <= 1'b0;
        clr_n <= 1'b0;
        repeat (8) @(posedge mclk);
        ld_n <= 1'b1;
        clr_n <= 1'b1;
        idle();
        st(16'h8000, 8'h00, 4'h0, 1'b0, 1);
        zs(16'h0000);
        send(24'h380001);
        st(16'h8000, 8'h00, 4'h0, 1'b1, 2);
        send(24'h3ffffe);
        st(16'h8000, 8'h00, 4'h0, 1'b0, 3);
        send(24'h380001);
        for (int m = 0; m < 4; m++) begin
            send(24'h200000 | 24'((m << 4) | (1 << m)));
        end
        send(24'h30000a);
        send(24'h1f1234);
        st(16'h1234, 8'he4, 4'ha, 1'b1, 4);
        zs(16'h1234);
        send(24'h280000);
        st(16'h0000, 8'he4, 4'ha, 1'b1, 5);
        send(24'h300000);
        send(24'h075678);
        st(16'h0000, 8'he4, 4'h0, 1'b1, 6);
        ld_n <= 1'b0;
        @(posedge mclk);
        ld_n <= 1'b1;
        repeat (2) @(posedge mclk);
        st(16'h5678, 8'he4, 4'h0, 1'b1, 7);
        clr_n <= 1'b0;
        @(posedge mclk);
        clr_n <= 1'b1;
        repeat (2) @(posedge mclk);
        st(16'h0000, 8'he4, 4'h0, 1'b1, 8);
        for (int s = 0; s < 2; s++) begin
            sel <= s[0];
            send(24'h1f1234);
            send(24'h2fffff);
            ld_n <= 1'b0;
            clr_n <= 1'b0;
            repeat (6) @(posedge mclk);
            ld_n <= 1'b1;
            clr_n <= 1'b1;
            idle();
            st({s[0], 15'h0}, 8'h00, 4'h0, 1'b0, 9 + s);
            zs(16'h0000);
        end
        test_done();
    end
endmodule
